//--- hw/rx_config_pattern_regs.v
// Operation
// - Force-widest bit selects widest filter and skips calibration.
// - Calibration policy: startup, none, on width change, or on writing 11.
// - Initialisation policy: startup, reserved, on width change, or forced.
// - Signal strength indicator enabled by bit 7 of register 9.
// - Signal strength range chosen by bit 6 of register 9.
// - Two-bit input power level readable at bits 5-4.
// - Frequency error indicator enabled by bit 3 of register 9.
// - Writing 0 to bit 2 starts correction; reads 1 until it ends.
// - Bit 1 reports last correction outcome, 1 meaning failure.
// - Bit 0 set stops correction being applied to the oscillator.
// - Overflow sets bit 7 of register 10; writing 1 resets integrator.
// - Bit 5 of register 10 picks sensitivity or linearity mode.
// - Bit 4 of register 10 enables pattern recognition.
// - Bits 3-2 select pattern length of 8, 16, 24 or 32 bits.
// - Bits 1-0 set tolerated mismatches from zero to three.
// - Frequency error readable as signed 16 bits, high byte first.
// - Pattern starts at register 13 bit 7; more bytes follow in 14-16.
// - Earliest window bit meets pattern MSB; newest bit meets active LSB.
// - Alternate decode bit changes the meaning of the width code.
// - Narrow enable takes width from nine-bit code in registers 21-22.
// - Three-bit high-pass cut-off code in bits 5-3 of register 22.
// - Oversampling is 32, or register 28 plus one when overridden.
// - Pattern found in pattern mode (fill bit 0) raises start flag; write 1 clears.
//
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
`include "rx_config_pattern_regs_consts.vh"

module rx_config_pattern_regs (
	input wire pclk,
	input wire presetn,
	input wire clk_en,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [1:0] signal_strength_level,
	input wire [15:0] freq_error_value,
	input wire freq_correction_done,
	input wire freq_correction_failed,
	input wire freq_integrator_overflow,
	input wire demod_bit,
	input wire demod_bit_valid,
	output reg bitsync_disable,
	output reg [1:0] filter_width_mode,
	output reg [8:0] filter_width_setting,
	output reg filter_calibrate,
	output reg filter_init,
	output reg [2:0] highpass_cutoff_code,
	output reg [8:0] oversample_ratio,
	output reg signal_strength_enable,
	output reg signal_strength_range,
	output reg freq_error_indicator_enable,
	output reg freq_correction_start,
	output reg freq_correction_bypass,
	output reg freq_integrator_reset,
	output reg quadrature_amp_enable,
	output reg rx_linearity_mode,
	output reg pattern_match,
	output reg start_detect
);

	// ************************************************************
	// Helpers
	// ************************************************************
	function mapped;
		input [5:0] idx;
		begin
			case (idx)
			`IDX_FILTER_CAL, `IDX_STRENGTH_CORR, `IDX_MODE_PATTERN,
			`IDX_FREQ_ERR_HIGH, `IDX_FREQ_ERR_LOW,
			`IDX_PATTERN_FIRST, `IDX_PATTERN_SECOND,
			`IDX_PATTERN_THIRD, `IDX_PATTERN_FOURTH,
			`IDX_EXTRA_WIDTH, `IDX_NARROW_HIGH, `IDX_NARROW_LOW_HPF,
			`IDX_OSR_SELECT, `IDX_OSR_VALUE, `IDX_START_DETECT:
				mapped = 1'b1;
			default:
				mapped = 1'b0;
			endcase
		end
	endfunction

	// Population count of the mismatch word.
	function [5:0] ones;
		input [31:0] v;
		integer i;
		begin
			ones = 6'h00;
			for (i = 0; i < 32; i = i + 1) begin
				ones = ones + {5'h00, v[i]};
			end
		end
	endfunction

	// ************************************************************
	// Storage
	// ************************************************************
	reg [7:0] filter_cal;
	reg [7:0] strength_corr;
	reg [7:0] mode_pattern;
	reg [15:0] freq_error_hold;
	reg [31:0] pattern;
	reg [7:0] extra_width;
	reg [7:0] narrow_high;
	reg [7:0] narrow_low_hpf;
	reg [7:0] osr_select;
	reg [7:0] osr_value;
	reg fill_mode;
	reg [1:0] level_meta;
	reg [1:0] level_sync;
	reg startup_pending;
	reg width_valid;
	reg [31:0] window;
	reg [5:0] received;
	reg check_pending;

	wire [5:0] idx = paddr[7:2];
	wire setup = psel & ~penable;
	wire wr_done = psel & penable & pready & pwrite & ~pslverr;
	wire wr_cal = wr_done & (idx == `IDX_FILTER_CAL);
	wire wr_corr = wr_done & (idx == `IDX_STRENGTH_CORR);
	wire wr_mode = wr_done & (idx == `IDX_MODE_PATTERN);
	wire wr_start = wr_done & (idx == `IDX_START_DETECT);
	wire corr_running = strength_corr[`BIT_CORR_RUN];

	// ************************************************************
	// Effective filter selection
	// ************************************************************
	reg [1:0] next_mode;
	reg [8:0] next_setting;

	always @* begin
		next_setting = {7'h00, filter_cal[6:5]};
		if (filter_cal[`BIT_FORCE_WIDEST]) begin
			next_mode = `WMODE_WIDEST;
			next_setting = 9'h000;
		end else if (extra_width[`BIT_NARROW_EN]) begin
			next_mode = `WMODE_NARROW;
			next_setting = {narrow_high[6:0], narrow_low_hpf[7:6]};
		end else if (extra_width[`BIT_ALT_DECODE]) begin
			next_mode = `WMODE_ALT;
		end else begin
			next_mode = `WMODE_NORMAL;
		end
	end

	wire width_changed = width_valid &
		({next_mode, next_setting} !=
		{filter_width_mode, filter_width_setting});
	wire [1:0] cal_policy = filter_cal[3:2];
	wire [1:0] init_policy = filter_cal[1:0];
	// A forced run needs the written value, not the stored one.
	wire [1:0] wr_cal_policy = pwdata[3:2];
	wire [1:0] wr_init_policy = pwdata[1:0];

	// ************************************************************
	// Pattern comparison
	// ************************************************************
	wire [1:0] psize = mode_pattern[3:2];
	// Size code 3 must give 32, so the sum is made six bits wide first.
	wire [5:0] active_bits = {1'b0, psize, 3'h0} + 6'h08;
	wire [31:0] active_mask;
	wire [31:0] expected;
	wire [31:0] diff;
	// Left-aligned pattern shifted down so its last active bit is bit 0.
	assign expected = pattern >> (6'h20 - active_bits);
	genvar g;
	generate
		for (g = 0; g < 32; g = g + 1) begin : mask_gen
			assign active_mask[g] = (g < active_bits);
		end
	endgenerate
	assign diff = (window ^ expected) & active_mask;
	// Nothing matches until a full window has arrived since enable.
	wire found = (received >= active_bits) &
		(ones(diff) <= {4'h0, mode_pattern[1:0]});

	// ************************************************************
	// Sequential logic
	// ************************************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			filter_cal <= `RST_BYTE;
			strength_corr <= `RST_BYTE;
			mode_pattern <= `RST_BYTE;
			freq_error_hold <= 16'h0000;
			pattern <= 32'h00000000;
			extra_width <= `RST_BYTE;
			narrow_high <= `RST_BYTE;
			narrow_low_hpf <= `RST_BYTE;
			osr_select <= `RST_BYTE;
			osr_value <= `RST_BYTE;
			fill_mode <= 1'b0;
			level_meta <= 2'h0;
			level_sync <= 2'h0;
			startup_pending <= 1'b1;
			width_valid <= 1'b0;
			window <= 32'h00000000;
			received <= 6'h00;
			check_pending <= 1'b0;
			bitsync_disable <= 1'b0;
			filter_width_mode <= `WMODE_NORMAL;
			filter_width_setting <= 9'h000;
			filter_calibrate <= 1'b0;
			filter_init <= 1'b0;
			highpass_cutoff_code <= 3'h0;
			oversample_ratio <= `OSR_DEFAULT;
			signal_strength_enable <= 1'b0;
			signal_strength_range <= 1'b0;
			freq_error_indicator_enable <= 1'b0;
			freq_correction_start <= 1'b0;
			freq_correction_bypass <= 1'b0;
			freq_integrator_reset <= 1'b0;
			quadrature_amp_enable <= 1'b0;
			rx_linearity_mode <= 1'b0;
			pattern_match <= 1'b0;
			start_detect <= 1'b0;
		end else if (clk_en) begin
			// Zero-wait slave: answer in the access cycle.
			pready <= setup;
			pslverr <= setup & ~mapped(idx);
			if (setup) begin
				prdata <= 32'h00000000;
				case (idx)
				`IDX_FILTER_CAL: prdata[7:0] <= filter_cal;
				`IDX_STRENGTH_CORR:
					prdata[7:0] <= {strength_corr[7:6], level_sync,
						strength_corr[3:0]};
				`IDX_MODE_PATTERN: prdata[7:0] <= mode_pattern;
				`IDX_FREQ_ERR_HIGH:
					prdata[7:0] <= freq_error_hold[15:8];
				`IDX_FREQ_ERR_LOW: prdata[7:0] <= freq_error_hold[7:0];
				`IDX_PATTERN_FIRST: prdata[7:0] <= pattern[31:24];
				`IDX_PATTERN_SECOND: prdata[7:0] <= pattern[23:16];
				`IDX_PATTERN_THIRD: prdata[7:0] <= pattern[15:8];
				`IDX_PATTERN_FOURTH: prdata[7:0] <= pattern[7:0];
				`IDX_EXTRA_WIDTH: prdata[7:0] <= extra_width;
				`IDX_NARROW_HIGH: prdata[7:0] <= narrow_high;
				`IDX_NARROW_LOW_HPF: prdata[7:0] <= narrow_low_hpf;
				`IDX_OSR_SELECT: prdata[7:0] <= osr_select;
				`IDX_OSR_VALUE: prdata[7:0] <= osr_value;
				`IDX_START_DETECT:
					prdata[7:0] <= {fill_mode, start_detect, 6'h00};
				default: prdata <= 32'h00000000;
				endcase
			end

			// Plain configuration writes.
			if (wr_cal) begin
				filter_cal <= pwdata[7:0];
			end
			if (wr_mode) begin
				mode_pattern[6:0] <= pwdata[6:0];
			end
			if (wr_done) begin
				case (idx)
				`IDX_PATTERN_FIRST: pattern[31:24] <= pwdata[7:0];
				`IDX_PATTERN_SECOND: pattern[23:16] <= pwdata[7:0];
				`IDX_PATTERN_THIRD: pattern[15:8] <= pwdata[7:0];
				`IDX_PATTERN_FOURTH: pattern[7:0] <= pwdata[7:0];
				`IDX_EXTRA_WIDTH: extra_width <= pwdata[7:0];
				`IDX_NARROW_HIGH: narrow_high <= pwdata[7:0];
				`IDX_NARROW_LOW_HPF: narrow_low_hpf <= pwdata[7:0];
				`IDX_OSR_SELECT: osr_select <= pwdata[7:0];
				`IDX_OSR_VALUE: osr_value <= pwdata[7:0];
				default: fill_mode <= fill_mode;
				endcase
			end

			// Register 9: plain bits, then run and result.
			if (wr_corr) begin
				strength_corr[7:6] <= pwdata[7:6];
				strength_corr[`BIT_FREQ_ERR_EN] <= pwdata[3];
				strength_corr[`BIT_CORR_BYPASS] <= pwdata[0];
			end
			freq_correction_start <= 1'b0;
			if (corr_running & freq_correction_done) begin
				strength_corr[`BIT_CORR_RUN] <= 1'b0;
				strength_corr[`BIT_CORR_RESULT] <= freq_correction_failed;
			end else if (wr_corr & ~pwdata[2] & ~corr_running) begin
				// A start while one runs is ignored.
				strength_corr[`BIT_CORR_RUN] <= 1'b1;
				freq_correction_start <= 1'b1;
			end

			// Overflow flag: the set wins over a same-cycle clear.
			freq_integrator_reset <= wr_mode & pwdata[7];
			if (freq_integrator_overflow) begin
				mode_pattern[`BIT_INTEG_OVERFLOW] <= 1'b1;
			end else if (wr_mode & pwdata[7]) begin
				mode_pattern[`BIT_INTEG_OVERFLOW] <= 1'b0;
			end

			// Level comes from analog comparators, hence the sync.
			level_meta <= signal_strength_level;
			level_sync <= level_meta;
			if (strength_corr[`BIT_FREQ_ERR_EN]) begin
				freq_error_hold <= freq_error_value;
			end

			// Filter selection and calibration triggers.
			width_valid <= 1'b1;
			filter_width_mode <= next_mode;
			filter_width_setting <= next_setting;
			startup_pending <= 1'b0;
			filter_calibrate <= (~filter_cal[`BIT_FORCE_WIDEST] &
				((startup_pending & (cal_policy == `POLICY_STARTUP)) |
				(width_changed & (cal_policy == `POLICY_ON_CHANGE)))) |
				// A forced run obeys the value being written, since
				// the stored force-widest bit is about to be replaced.
				(wr_cal & ~pwdata[`BIT_FORCE_WIDEST] &
				(wr_cal_policy == `POLICY_FORCE));
			filter_init <=
				(startup_pending & (init_policy == `POLICY_STARTUP)) |
				(width_changed & (init_policy == `POLICY_ON_CHANGE)) |
				(wr_cal & (wr_init_policy == `POLICY_FORCE));

			// Pass-through controls.
			bitsync_disable <= filter_cal[`BIT_BITSYNC_OFF];
			highpass_cutoff_code <= narrow_low_hpf[5:3];
			oversample_ratio <= osr_select[`BIT_OSR_OVERRIDE] ?
				({1'b0, osr_value} + 9'h001) : `OSR_DEFAULT;
			signal_strength_enable <=
				strength_corr[`BIT_STRENGTH_EN];
			signal_strength_range <=
				strength_corr[`BIT_STRENGTH_RANGE];
			freq_error_indicator_enable <=
				strength_corr[`BIT_FREQ_ERR_EN];
			freq_correction_bypass <=
				strength_corr[`BIT_CORR_BYPASS];
			quadrature_amp_enable <= mode_pattern[`BIT_QUAD_AMP];
			rx_linearity_mode <= mode_pattern[`BIT_RX_MODE];

			// Bit window: newest bit enters at bit 0.
			check_pending <= 1'b0;
			if (demod_bit_valid & mode_pattern[`BIT_PATTERN_EN]) begin
				window <= {window[30:0], demod_bit};
				check_pending <= 1'b1;
				// The count saturates at 32 so a long run cannot wrap it.
				if (received != `PATTERN_BITS) begin
					received <= received + 6'h01;
				end
			end else if (~mode_pattern[`BIT_PATTERN_EN]) begin
				received <= 6'h00;
			end
			pattern_match <= check_pending & found &
				mode_pattern[`BIT_PATTERN_EN];

			// Start flag: in pattern mode hardware sets, write 1 clears.
			if (wr_start) begin
				fill_mode <= pwdata[`BIT_FILL_MODE];
			end
			if (~fill_mode & check_pending & found &
				mode_pattern[`BIT_PATTERN_EN]) begin
				start_detect <= 1'b1;
			end else if (wr_start & ~fill_mode) begin
				if (pwdata[`BIT_START_FLAG]) begin
					start_detect <= 1'b0;
				end
			end else if (wr_start) begin
				// In fill mode 1 the flag is a plain bit owned by software.
				start_detect <= pwdata[`BIT_START_FLAG];
			end
		end
	end

endmodule // rx_config_pattern_regs

//--- hw/rx_config_pattern_regs_consts.vh
`ifndef RX_CONFIG_PATTERN_REGS_CONSTS_VH
`define RX_CONFIG_PATTERN_REGS_CONSTS_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define IDX_FILTER_CAL 6'h08
`define IDX_STRENGTH_CORR 6'h09
`define IDX_MODE_PATTERN 6'h0A
`define IDX_FREQ_ERR_HIGH 6'h0B
`define IDX_FREQ_ERR_LOW 6'h0C
`define IDX_PATTERN_FIRST 6'h0D
`define IDX_PATTERN_SECOND 6'h0E
`define IDX_PATTERN_THIRD 6'h0F
`define IDX_PATTERN_FOURTH 6'h10
`define IDX_EXTRA_WIDTH 6'h13
`define IDX_NARROW_HIGH 6'h15
`define IDX_NARROW_LOW_HPF 6'h16
`define IDX_OSR_SELECT 6'h1B
`define IDX_OSR_VALUE 6'h1C
`define IDX_START_DETECT 6'h1D

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_BITSYNC_OFF 7
`define BIT_FORCE_WIDEST 4
`define BIT_STRENGTH_EN 7
`define BIT_STRENGTH_RANGE 6
`define BIT_FREQ_ERR_EN 3
`define BIT_CORR_RUN 2
`define BIT_CORR_RESULT 1
`define BIT_CORR_BYPASS 0
`define BIT_INTEG_OVERFLOW 7
`define BIT_QUAD_AMP 6
`define BIT_RX_MODE 5
`define BIT_PATTERN_EN 4
`define BIT_NARROW_EN 2
`define BIT_ALT_DECODE 1
`define BIT_OSR_OVERRIDE 4
`define BIT_FILL_MODE 7
`define BIT_START_FLAG 6

// ****************************************************************
// Codes, reset values and fixed counts
// ****************************************************************
`define POLICY_STARTUP 2'h0
`define POLICY_NONE 2'h1
`define POLICY_ON_CHANGE 2'h2
`define POLICY_FORCE 2'h3
`define WMODE_NORMAL 2'h0
`define WMODE_ALT 2'h1
`define WMODE_NARROW 2'h2
`define WMODE_WIDEST 2'h3
`define RST_BYTE 8'h00
`define OSR_DEFAULT 9'h020
`define PATTERN_BITS 6'h20

`endif

//--- test/apb_host_model.sv
`timescale 1ns/10ps
module apb_host_model (
	input wire pclk,
	output reg psel,
	output reg penable,
	output reg pwrite,
	output reg [7:0] paddr,
	output reg [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// Released address and data lines are inverted so stale values cannot pass for valid.
	task xfer(input w, input [5:0] i, input [7:0] d, output [7:0] q,
		output e);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= {i, 2'h0};
			pwdata <= {24'h0, d};
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (!pready)
				@(posedge pclk);
			q = prdata[7:0];
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			paddr <= ~paddr;
			pwdata <= ~pwdata;
		end
	endtask
endmodule // apb_host_model

//--- test/rx_config_pattern_regs_props.sv
`timescale 1ns/10ps
module rx_config_pattern_regs_props (
	input wire pclk,
	input wire presetn,
	input wire clk_en,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire demod_bit_valid,
	input wire [1:0] filter_width_mode,
	input wire filter_calibrate,
	input wire [2:0] highpass_cutoff_code,
	input wire signal_strength_enable,
	input wire freq_correction_start,
	input wire freq_integrator_reset,
	input wire rx_linearity_mode,
	input wire pattern_match
);
	// ****
	// Access decode
	// ****
	wire [5:0] idx = paddr[7:2];
	wire wr = psel && penable && pready && pwrite;
	wire hit = (idx >= 6'h08 && idx <= 6'h10) || idx == 6'h13 ||
		idx == 6'h15 || idx == 6'h16 || (idx >= 6'h1B && idx <= 6'h1D);
	wire go = wr && idx == 6'h09 && !pwdata[2];

	// A frozen cycle stretches every latency, so it is left unchecked.
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn || !clk_en);

	ready_after_setup_a: assert property (psel && !penable |=> pready)
		else $error("pready not raised after setup");
	unmapped_error_a: assert property (pready |-> pslverr == !hit)
		else $error("pslverr does not follow the address map");
	read_upper_zero_a: assert property (
		pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	corr_start_cause_a: assert property (
		freq_correction_start |-> $past(go) || $past(go, 2))
		else $error("correction start without a start write");
	strength_enable_a: assert property (
		wr && idx == 6'h09 |-> ##2
		signal_strength_enable == $past(pwdata[7], 2))
		else $error("strength enable does not follow its bit");
	linearity_mode_a: assert property (
		wr && idx == 6'h0A |-> ##2 rx_linearity_mode == $past(pwdata[5], 2))
		else $error("receiver mode does not follow its bit");
	highpass_code_a: assert property (
		wr && idx == 6'h16 |-> ##2
		highpass_cutoff_code == $past(pwdata[5:3], 2))
		else $error("high-pass code does not follow its field");
	widest_no_cal_a: assert property (
		filter_width_mode == 2'h3 && $past(filter_width_mode) == 2'h3
		|-> !$past(filter_calibrate))
		else $error("calibration while widest filter forced");
	integ_reset_a: assert property (
		wr && idx == 6'h0A && pwdata[7] |-> ##[1:2] freq_integrator_reset)
		else $error("integrator reset not pulsed");
	match_after_bit_a: assert property (
		pattern_match |-> $past(demod_bit_valid, 2) ||
		$past(demod_bit_valid, 3))
		else $error("pattern match without a received bit");
	start_seen_c: cover property (freq_correction_start);
	match_seen_c: cover property (pattern_match);
	refused_seen_c: cover property (pready && pslverr);
endmodule // rx_config_pattern_regs_props

bind rx_config_pattern_regs rx_config_pattern_regs_props
	rx_config_pattern_regs_props_i (.pclk, .presetn, .clk_en, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.demod_bit_valid, .filter_width_mode, .filter_calibrate,
	.highpass_cutoff_code, .signal_strength_enable,
	.freq_correction_start, .freq_integrator_reset, .rx_linearity_mode,
	.pattern_match);

//--- test/tb_rx_config_pattern_regs.sv
`timescale 1ns/10ps
module tb_rx_config_pattern_regs;
	reg pclk = 1'b0;
	reg presetn = 1'b0;
	reg clk_en = 1'b1;
	reg [1:0] signal_strength_level = 2'h0;
	reg [15:0] freq_error_value = 16'h8123;
	reg freq_correction_done = 1'b0;
	reg freq_correction_failed = 1'b0;
	reg freq_integrator_overflow = 1'b0;
	reg demod_bit = 1'b0;
	reg demod_bit_valid = 1'b0;
	wire psel, penable, pwrite, pready, pslverr;
	wire [7:0] paddr;
	wire [31:0] pwdata, prdata;
	wire [1:0] filter_width_mode;
	wire [8:0] filter_width_setting, oversample_ratio;
	wire [2:0] highpass_cutoff_code;
	wire bitsync_disable, filter_calibrate, filter_init, start_detect;
	wire signal_strength_enable, signal_strength_range, pattern_match;
	wire freq_error_indicator_enable, freq_correction_start;
	wire freq_correction_bypass, freq_integrator_reset;
	wire quadrature_amp_enable, rx_linearity_mode;
	integer err_count = 0;
	integer check_count = 0;
	integer n_start = 0, n_rst = 0, n_match = 0, n_cal = 0, n_init = 0;
	reg [7:0] q;
	reg e;

	always #12.5 pclk = ~pclk;

	rx_config_pattern_regs rx_config_pattern_regs_i (.pclk, .presetn,
		.clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .signal_strength_level, .freq_error_value,
		.freq_correction_done, .freq_correction_failed,
		.freq_integrator_overflow, .demod_bit, .demod_bit_valid,
		.bitsync_disable, .filter_width_mode, .filter_width_setting,
		.filter_calibrate, .filter_init, .highpass_cutoff_code,
		.oversample_ratio, .signal_strength_enable, .signal_strength_range,
		.freq_error_indicator_enable, .freq_correction_start,
		.freq_correction_bypass, .freq_integrator_reset,
		.quadrature_amp_enable, .rx_linearity_mode, .pattern_match,
		.start_detect);
	apb_host_model apb_host_model_i (.pclk, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr);

	// Outputs are unknown until the first reset edge, so count after it.
	always @(posedge pclk) begin
		if (presetn) begin
			n_start <= n_start + freq_correction_start;
			n_rst <= n_rst + freq_integrator_reset;
			n_match <= n_match + pattern_match;
			n_cal <= n_cal + filter_calibrate;
			n_init <= n_init + filter_init;
		end
	end

	task chk(input string s, input [31:0] got, input [31:0] exp);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("ERROR %s expected %h seen %h", s, exp, got);
			end
		end
	endtask
	// Trailing edges let pulses and lagging outputs settle before checks.
	task wr(input [5:0] i, input [7:0] d);
		begin
			apb_host_model_i.xfer(1'b1, i, d, q, e);
			repeat (4) @(posedge pclk);
		end
	endtask
	task rd(input [5:0] i, input [7:0] x);
		begin
			apb_host_model_i.xfer(1'b0, i, 8'h00, q, e);
			chk($sformatf("reg %h", i), q, x);
		end
	endtask
	function hit(input [5:0] k);
		hit = (k >= 6'h08 && k <= 6'h10) || k == 6'h13 || k == 6'h15 ||
			k == 6'h16 || (k >= 6'h1B && k <= 6'h1D);
	endfunction
	function plain(input [5:0] k);
		plain = k != 6'h09 && k != 6'h0B && k != 6'h0C && k != 6'h1D;
	endfunction

	// ****
	// Scenarios
	// ****
	task t_reset;
		reg [5:0] k;
		begin
			for (k = 6'h08; k < 6'h20; k = k + 6'h01) begin
				rd(k, 8'h00);
				chk("pslverr", e, !hit(k));
			end
			chk("osr", oversample_ratio, 9'h020);
			$display("reset test done");
		end
	endtask
	task t_rw;
		reg [5:0] k;
		reg [7:0] x;
		begin
			for (k = 6'h08; k < 6'h20; k = k + 6'h01)
				if (plain(k))
					wr(k, 8'h5A ^ {2'h0, k});
			chk("quad", quadrature_amp_enable, 1'b1);
			for (k = 6'h08; k < 6'h20; k = k + 6'h01) begin
				x = hit(k) ? 8'h5A ^ {2'h0, k} : 8'h00;
				if (plain(k))
					rd(k, k == 6'h0A ? x & 8'h7F : x);
			end
			$display("read write test done");
		end
	endtask
	task t_width;
		integer c, i;
		begin
			wr(6'h08, 8'hC0);
			chk("bsync", bitsync_disable, 1'b1);
			wr(6'h13, 8'h00);
			chk("mode", filter_width_mode, 2'h0);
			chk("width", filter_width_setting, 9'h002);
			wr(6'h13, 8'h02);
			chk("mode", filter_width_mode, 2'h1);
			wr(6'h15, 8'h41);
			wr(6'h16, 8'hE8);
			wr(6'h13, 8'h06);
			chk("mode", filter_width_mode, 2'h2);
			chk("width", filter_width_setting, 9'h107);
			chk("hpf", highpass_cutoff_code, 3'h5);
			wr(6'h1C, 8'h07);
			wr(6'h1B, 8'h10);
			chk("osr", oversample_ratio, 9'h008);
			wr(6'h13, 8'h00);
			c = n_cal;
			i = n_init;
			wr(6'h08, 8'h5C);
			chk("mode", filter_width_mode, 2'h3);
			wr(6'h08, 8'h4C);
			wr(6'h08, 8'h25);
			wr(6'h08, 8'h0A);
			wr(6'h08, 8'h03);
			chk("cal", n_cal - c, 2);
			chk("init", n_init - i, 2);
			$display("width test done");
		end
	endtask
	task corr_end(input f);
		begin
			@(posedge pclk);
			freq_correction_failed <= f;
			freq_correction_done <= 1'b1;
			@(posedge pclk);
			freq_correction_done <= 1'b0;
		end
	endtask
	task t_corr;
		begin
			@(posedge pclk);
			signal_strength_level <= 2'h3;
			wr(6'h09, 8'hC8);
			chk("start", n_start, 1);
			chk("signal_strength_enable", signal_strength_enable, 1'b1);
			chk("range", signal_strength_range, 1'b1);
			chk("fei", freq_error_indicator_enable, 1'b1);
			chk("bypass", freq_correction_bypass, 1'b0);
			rd(6'h09, 8'hFC);
			wr(6'h09, 8'hC8);
			chk("start", n_start, 1);
			corr_end(1'b1);
			rd(6'h09, 8'hFA);
			rd(6'h0B, 8'h81);
			rd(6'h0C, 8'h23);
			wr(6'h09, 8'h0D);
			chk("bypass", freq_correction_bypass, 1'b1);
			rd(6'h09, 8'h3B);
			wr(6'h09, 8'h08);
			corr_end(1'b0);
			chk("start", n_start, 2);
			rd(6'h09, 8'h38);
			$display("correction test done");
		end
	endtask
	task t_ovf;
		integer r;
		begin
			wr(6'h0A, 8'h20);
			chk("linear", rx_linearity_mode, 1'b1);
			@(posedge pclk);
			freq_integrator_overflow <= 1'b1;
			@(posedge pclk);
			freq_integrator_overflow <= 1'b0;
			rd(6'h0A, 8'hA0);
			r = n_rst;
			wr(6'h0A, 8'hA0);
			chk("integ", n_rst - r, 1);
			rd(6'h0A, 8'h20);
			$display("overflow test done");
		end
	endtask
	// An overflow pulse seen only while frozen must leave the flag clear.
	task t_freeze;
		begin
			@(posedge pclk);
			clk_en <= 1'b0;
			freq_integrator_overflow <= 1'b1;
			@(posedge pclk);
			clk_en <= 1'b1;
			freq_integrator_overflow <= 1'b0;
			rd(6'h0A, 8'h20);
			$display("freeze test done");
		end
	endtask
	// Disabling first clears the bit count, so only the last window counts.
	task try(input [7:0] c, input [31:0] v, input integer n, input integer x);
		integer m, k;
		begin
			wr(6'h0A, 8'h00);
			wr(6'h0A, c);
			m = n_match;
			for (k = n - 1; k >= 0; k = k - 1) begin
				@(posedge pclk);
				demod_bit <= v[k];
				demod_bit_valid <= 1'b1;
				@(posedge pclk);
				demod_bit_valid <= 1'b0;
			end
			repeat (5) @(posedge pclk);
			chk("match", n_match - m, x);
		end
	endtask
	task t_pat;
		begin
			wr(6'h0D, 8'h93);
			wr(6'h0E, 8'hAA);
			try(8'h00, 32'h93, 8, 0);
			try(8'h10, 32'h93, 8, 1);
			chk("sdet", start_detect, 1'b1);
			rd(6'h1D, 8'h40);
			wr(6'h1D, 8'h40);
			rd(6'h1D, 8'h00);
			wr(6'h1D, 8'hC0);
			wr(6'h1D, 8'hC0);
			rd(6'h1D, 8'hC0);
			wr(6'h1D, 8'h00);
			try(8'h10, 32'h92, 8, 0);
			try(8'h11, 32'h92, 8, 1);
			try(8'h14, 32'h93AA, 16, 1);
			try(8'h18, 32'h93AA55, 24, 1);
			try(8'h1F, 32'h93AA554D, 32, 1);
			$display("pattern test done");
		end
	endtask

	task finish_test;
		begin
			$display("checks %0d errors %0d", check_count, err_count);
			if (err_count == 0 && check_count > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask

	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_rw;
		t_width;
		t_corr;
		t_ovf;
		t_freeze;
		t_pat;
		finish_test;
	end
	initial begin
		#1000000;
		err_count = err_count + 1;
		finish_test;
	end
endmodule // tb_rx_config_pattern_regs
